// *** verilog/amem_pkg.sv ***
package amem_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BANK0 = 8'h04;
    localparam logic [7:0] OFS_BANK1 = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0c;
    localparam logic [7:0] OFS_WDATA = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_RDATA = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_ASYNC_BIT = 0;
    localparam int CTRL_TURN_BIT = 1;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_BANK_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_STALL_BIT = 1;
    localparam int STAT_LASTWR_BIT = 2;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;
    localparam int TIMING_W = 14;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [13:0] BANK_RST = 14'h0001;
    // ----------------------------------------
    // timing: MEM_DIV in sys_clk cycles, the rest in memory clock ticks
    // ----------------------------------------
    localparam logic [7:0] MEM_DIV = 8'h02;
    localparam logic [7:0] TURN_READ = 8'h03;
    localparam logic [7:0] TURN_R2W = 8'h04;
    localparam logic [7:0] TURN_W2W = 8'h01;
    localparam logic [7:0] TURN_W2R = 8'h03;
    localparam logic [7:0] GAP_FREE = 8'hff;
    // per-bank timing: idle, read hold, write hold, wait states
    typedef struct packed {
        logic [2:0] idleSpan;
        logic [2:0] readHoldSpan;
        logic [2:0] holdSpan;
        logic [4:0] waitStates;
    } bank_timing_t;
    typedef enum logic [1:0] {RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2} axi_resp_t;
endpackage : amem_pkg

// *** verilog/async_memory_strobe_sequencer.sv ***
module async_memory_strobe_sequencer
    import amem_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // memory pins
    output logic [1:0] bank_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    input wire logic memory_acknowledge,
    output logic [ADDR_W-1:0] memAddr,
    output logic [DATA_W-1:0] memDataOut,
    output logic memDataOe,
    input wire logic [DATA_W-1:0] memDataIn
);
    typedef enum {ST_IDLE, ST_GAP, ST_SELECT, ST_STROBE, ST_HOLD, ST_RELEASE} seq_state_t;

    logic [1:0] ctrl_r;
    bank_timing_t bank_r [2];
    logic [ADDR_W-1:0] addrReg_r;
    logic [DATA_W-1:0] wdataReg_r, rdataReg_r;
    logic [7:0] awAddr_r, divCnt_r, cnt_r, sinceRise_r, gapNeed;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic [2:0] ackSync_r;
    logic awHeld_r, wHeld_r, doWrite, startCmd, tick, ackLevel_r;
    seq_state_t state_r;
    logic busy_r, curWrite_r, curBank_r, prevWrite_r, prevBank_r, stall_r;
    logic pendWrite_r, pendBank_r;
    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    assign awready = !awHeld_r && !bvalid;
    assign wready = !wHeld_r && !bvalid;
    assign arready = !rvalid;
    assign doWrite = awHeld_r && wHeld_r && !bvalid;

    // hold address and data until both have arrived
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {awHeld_r, wHeld_r} <= 2'h0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are in
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= (awAddr_r <= OFS_CMD && awAddr_r[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // register writes; only low bytes matter for the narrow fields
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RST;
            bank_r <= '{BANK_RST, BANK_RST};
            addrReg_r <= 24'h000000;
            wdataReg_r <= 8'h00;
        end else if (doWrite) begin
            case (awAddr_r)
                OFS_CTRL: if (wStrb_r[0]) ctrl_r <= wData_r[1:0];
                OFS_BANK0: begin
                    if (wStrb_r[0]) bank_r[0][7:0] <= wData_r[7:0];
                    if (wStrb_r[1]) bank_r[0][13:8] <= wData_r[13:8];
                end
                OFS_BANK1: begin
                    if (wStrb_r[0]) bank_r[1][7:0] <= wData_r[7:0];
                    if (wStrb_r[1]) bank_r[1][13:8] <= wData_r[13:8];
                end
                OFS_ADDR: begin
                    if (wStrb_r[0]) addrReg_r[7:0] <= wData_r[7:0];
                    if (wStrb_r[1]) addrReg_r[15:8] <= wData_r[15:8];
                    if (wStrb_r[2]) addrReg_r[23:16] <= wData_r[23:16];
                end
                OFS_WDATA: if (wStrb_r[0]) wdataReg_r <= wData_r[7:0];
                default: ;
            endcase
        end
    end
    // command write starts an access only when idle and in async mode
    assign startCmd = doWrite && awAddr_r == OFS_CMD && wStrb_r[0] && !busy_r
        && ctrl_r[CTRL_ASYNC_BIT];

    // register reads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (araddr)
                OFS_CTRL: rdata <= {30'h0, ctrl_r};
                OFS_BANK0: rdata <= {18'h0, bank_r[0]};
                OFS_BANK1: rdata <= {18'h0, bank_r[1]};
                OFS_ADDR: rdata <= {8'h0, addrReg_r};
                OFS_WDATA: rdata <= {24'h0, wdataReg_r};
                OFS_CMD: rdata <= {30'h0, pendBank_r, pendWrite_r};
                OFS_RDATA: rdata <= {24'h0, rdataReg_r};
                OFS_STATUS: rdata <= {29'h0, prevWrite_r, stall_r, busy_r};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
    // ----------------------------------------
    // memory clock enable and acknowledge sync
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt_r <= 8'h00;
        end else begin
            divCnt_r <= (divCnt_r == MEM_DIV - 8'h01) ? 8'h00 : divCnt_r + 8'h01;
        end
    end
    assign tick = (divCnt_r == MEM_DIV - 8'h01);
    // three stages, level taken when the last two agree
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {ackSync_r, ackLevel_r} <= 4'hf;
        end else begin
            ackSync_r <= {ackSync_r[1:0], memory_acknowledge};
            if (ackSync_r[1] == ackSync_r[2]) ackLevel_r <= ackSync_r[2];
        end
    end
    // ----------------------------------------
    // turnaround gap from last strobe rise
    // ----------------------------------------
    function automatic logic [7:0] maxOf(input logic [7:0] a, input logic [7:0] b);
        maxOf = (a > b) ? a : b;
    endfunction : maxOf
    always_comb begin
        logic [7:0] rh, ic, hd;
        rh = {5'h0, bank_r[prevBank_r].readHoldSpan};
        ic = {5'h0, bank_r[pendBank_r].idleSpan};
        hd = {5'h0, bank_r[prevBank_r].holdSpan};
        if (prevWrite_r) begin
            gapNeed = hd + (pendWrite_r ? TURN_W2W : TURN_W2R);
        end else if (pendWrite_r) begin
            gapNeed = rh + maxOf(ic, TURN_R2W);
        end else if (!ctrl_r[CTRL_TURN_BIT]) begin
            gapNeed = (pendBank_r == prevBank_r) ? rh : rh + ic;
        end else begin
            gapNeed = (pendBank_r == prevBank_r) ? rh + TURN_READ
                : rh + maxOf(ic, TURN_READ);
        end
    end
    // ticks since the last strobe rise, saturating
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sinceRise_r <= GAP_FREE;
        end else if (tick) begin
            if (state_r == ST_STROBE) sinceRise_r <= 8'h00;
            else if (sinceRise_r != GAP_FREE) sinceRise_r <= sinceRise_r + 8'h01;
        end
    end
    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            {busy_r, pendWrite_r, pendBank_r, curWrite_r, curBank_r} <= 5'h00;
            {prevWrite_r, prevBank_r, stall_r} <= 3'h0;
            cnt_r <= 8'h00;
            bank_select_n <= 2'h3;
            {read_strobe_n, write_strobe_n} <= 2'h3;
            memAddr <= 24'h000000;
            memDataOut <= 8'h00;
            memDataOe <= 1'b0;
            rdataReg_r <= 8'h00;
        end else begin
            if (startCmd) begin
                busy_r <= 1'b1;
                pendWrite_r <= wData_r[CMD_WRITE_BIT];
                pendBank_r <= wData_r[CMD_BANK_BIT];
                state_r <= ST_GAP;
            end
            if (tick) begin
                case (state_r)
                    ST_IDLE: ;
                    ST_GAP: begin
                        if (sinceRise_r >= gapNeed) begin
                            curWrite_r <= pendWrite_r;
                            curBank_r <= pendBank_r;
                            memAddr <= addrReg_r;
                            bank_select_n <= pendBank_r ? 2'h1 : 2'h2;
                            state_r <= ST_SELECT;
                        end
                    end
                    ST_SELECT: begin
                        // strobe one tick after select
                        read_strobe_n <= curWrite_r;
                        write_strobe_n <= !curWrite_r;
                        memDataOut <= wdataReg_r;
                        memDataOe <= curWrite_r;
                        cnt_r <= maxOf({3'h0, bank_r[curBank_r].waitStates}, 8'h01);
                        state_r <= ST_STROBE;
                    end
                    ST_STROBE: begin
                        stall_r <= (cnt_r <= 8'h01) && !ackLevel_r;
                        if (cnt_r > 8'h01) begin
                            cnt_r <= cnt_r - 8'h01;
                        end else if (ackLevel_r) begin
                            read_strobe_n <= 1'b1;
                            write_strobe_n <= 1'b1;
                            if (!curWrite_r) rdataReg_r <= memDataIn;
                            cnt_r <= curWrite_r ? {5'h0, bank_r[curBank_r].holdSpan}
                                : {5'h0, bank_r[curBank_r].readHoldSpan};
                            prevWrite_r <= curWrite_r;
                            prevBank_r <= curBank_r;
                            state_r <= ST_HOLD;
                        end
                    end
                    ST_HOLD: begin
                        // select, address and data stay put
                        if (cnt_r != 8'h00) begin
                            cnt_r <= cnt_r - 8'h01;
                        end else begin
                            bank_select_n <= 2'h3;
                            state_r <= curWrite_r ? ST_RELEASE : ST_IDLE;
                            busy_r <= curWrite_r;
                        end
                    end
                    ST_RELEASE: begin
                        memDataOe <= 1'b0;
                        busy_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule : async_memory_strobe_sequencer

// *** sim/amem_monitor.sv ***
module amem_monitor
    import amem_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // memory pins
    input wire logic [1:0] bank_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic memory_acknowledge,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic [DATA_W-1:0] memDataOut,
    input wire logic memDataOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // strobe pin relations
    one_bank_a: assert property (!(read_strobe_n && write_strobe_n) |-> ^bank_select_n)
        else $error("strobe without one bank select");
    select_lead_a: assert property ($fell(read_strobe_n && write_strobe_n) |->
        $past(bank_select_n, 2) != 2'b11 && $past(bank_select_n, 3) == 2'b11)
        else $error("select lead before strobe wrong");
    addr_hold_a: assert property (bank_select_n != 2'b11 && $past(bank_select_n) != 2'b11
        |-> $stable(memAddr))
        else $error("address moved while selected");
    ack_wait_a: assert property ($rose(read_strobe_n && write_strobe_n)
        |-> $past(memory_acknowledge, 2))
        else $error("strobe ended while ack low");
    // write data bus relations
    data_drive_a: assert property (!write_strobe_n |-> memDataOe)
        else $error("write strobe low without data");
    data_hold_a: assert property (memDataOe && $past(memDataOe) |-> $stable(memDataOut))
        else $error("write data moved while driven");
    data_release_a: assert property ($fell(memDataOe) |->
        $past(bank_select_n, 2) == 2'b11 && $past(bank_select_n, 3) != 2'b11)
        else $error("data bus release not one tick after select");
    read_clear_a: assert property ($fell(read_strobe_n) |-> !$past(memDataOe, 4))
        else $error("data bus released too late before read");
endmodule : amem_monitor

// *** sim/async_memory_model.sv ***
module async_memory_model
    import amem_pkg::*;
(
    // clock and reset, for measuring, ack stretching and storing writes
    input wire logic sys_clk,
    input wire logic nrst,
    // memory pins
    input wire logic [1:0] bank_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic [DATA_W-1:0] memDataOut,
    input wire logic memDataOe,
    output logic memory_acknowledge,
    output logic [DATA_W-1:0] memDataIn,
    // stretch request and measured spans in cycles
    input wire logic [7:0] stretchLen,
    output logic [7:0] lowWidth,
    output logic [7:0] gapWidth,
    output logic [7:0] holdWidth,
    output logic [7:0] oeTail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] now, tRise, tFall, ackCnt;
    logic stbQ, wrQ, selQ, oeQ;
    logic [DATA_W-1:0] lastIn;
    logic [DATA_W-1:0] mem [16];
    wire logic stb = read_strobe_n & write_strobe_n;
    // edge timestamps and spans
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {now, tRise, tFall} <= '0;
            {stbQ, selQ, oeQ} <= 3'h6;
        end else begin
            now <= now + 8'h1;
            {stbQ, selQ, oeQ} <= {stb, &bank_select_n, memDataOe};
            if (stbQ && !stb) tFall <= now;
            if (stbQ && !stb) gapWidth <= now - tRise;
            if (!stbQ && stb) tRise <= now;
            if (!stbQ && stb) lowWidth <= now - tFall;
            if (!selQ && &bank_select_n) holdWidth <= now - tRise;
            if (oeQ && !memDataOe) oeTail <= now - tRise;
        end
    end
    // ack low for stretchLen cycles after a strobe falls
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) ackCnt <= '0;
        else if (stbQ && !stb) ackCnt <= stretchLen;
        else if (ackCnt != 8'h0) ackCnt <= ackCnt - 8'h1;
    end
    assign memory_acknowledge = (ackCnt == 8'h0);
    // store on write strobe rise, drive stored data only while read strobe low with one bank selected, inverted last value otherwise
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wrQ <= 1'b1;
            lastIn <= '0;
        end else begin
            wrQ <= write_strobe_n;
            lastIn <= memDataIn;
            if (!wrQ && write_strobe_n) mem[memAddr[3:0]] <= memDataOut;
        end
    end
    assign memDataIn = (!read_strobe_n && ^bank_select_n) ? mem[memAddr[3:0]] : ~lastIn;
endmodule : async_memory_model

// *** sim/test_async_memory_strobe_sequencer.sv ***
module test_async_memory_strobe_sequencer
    import amem_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, read_strobe_n, write_strobe_n;
    logic memory_acknowledge, memDataOe;
    logic [7:0] awaddr, araddr, stretchLen, lowWidth, gapWidth, holdWidth, oeTail;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp, bank_select_n;
    logic [ADDR_W-1:0] memAddr;
    logic [DATA_W-1:0] memDataOut, memDataIn;
    logic [7:0] gapCase [8] = '{8'h01, 8'h18, 8'h25, 8'h84, 8'h98, 8'hb8, 8'h62, 8'h54};
    int waits [3] = '{0, 2, 31};
    int n_errors = 0;
    int checked = 0;
    async_memory_strobe_sequencer dut (
        .sys_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .bank_select_n, .read_strobe_n, .write_strobe_n, .memory_acknowledge,
        .memAddr, .memDataOut, .memDataOe, .memDataIn
    );
    async_memory_model model (
        .sys_clk, .nrst, .bank_select_n, .read_strobe_n, .write_strobe_n, .memAddr,
        .memDataOut, .memDataOe, .memory_acknowledge, .memDataIn, .stretchLen, .lowWidth,
        .gapWidth, .holdWidth, .oeTail
    );
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        forever begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rsp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge sys_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                {rd, rsp} = {rdata, rresp};
                rready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd
    task automatic set_bank(input logic [7:0] a, input logic [2:0] ic, rh, h, input logic [4:0] w);
        bank_timing_t bt;
        bt = '{ic, rh, h, w};
        axi_wr(a, 32'(bt));
    endtask : set_bank
    // one memory access, then poll until idle
    task automatic mem_op(input logic wr, input logic bk, input logic [7:0] d);
        // reads skip the data write to keep the turnaround path short
        if (wr) axi_wr(OFS_WDATA, {24'h0, d});
        axi_wr(OFS_CMD, {30'h0, bk, wr});
        rd = 32'h1;
        while (rd[STAT_BUSY_BIT] !== 1'b0) axi_rd(OFS_STATUS);
    endtask : mem_op
    // watchdog
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        nrst = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        stretchLen = 8'h0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        axi_rd(OFS_BANK0);
        check(rd, 32'(BANK_RST));
        axi_rd(OFS_CTRL);
        check(rd, 32'(CTRL_RST));
        axi_wr(OFS_STATUS, 32'h1);
        check(rsp, RESP_SLVERR);
        axi_rd(8'h20);
        check(rsp, RESP_SLVERR);
        $display("register test done");
        set_bank(OFS_BANK0, 3'h0, 3'h0, 3'h0, 5'h07);
        axi_wr(OFS_CMD, 32'h0);
        axi_rd(OFS_STATUS);
        check(rd[STAT_BUSY_BIT], 1'b0);
        check(bank_select_n, 2'b11);
        axi_wr(OFS_CTRL, 32'h1);
        axi_wr(OFS_ADDR, 32'h3);
        $display("mode test done");
        foreach (waits[i]) begin
            set_bank(OFS_BANK0, 3'h0, 3'h0, 3'h0, 5'(waits[i]));
            mem_op(1'b1, 1'b0, 8'h5a + 8'(i));
            check(lowWidth, 2 * ((waits[i] == 0) ? 1 : waits[i]));
            mem_op(1'b0, 1'b0, 8'h0);
            check(lowWidth, 2 * ((waits[i] == 0) ? 1 : waits[i]));
            axi_rd(OFS_RDATA);
            check(rd, 32'h5a + i);
        end
        $display("strobe width test done");
        set_bank(OFS_BANK0, 3'h0, 3'h3, 3'h2, 5'h01);
        mem_op(1'b1, 1'b0, 8'hc3);
        check(holdWidth, 6);
        check(oeTail, 8);
        axi_rd(OFS_STATUS);
        check(rd, 32'h4);
        axi_rd(OFS_CMD);
        check(rd, 32'h1);
        mem_op(1'b0, 1'b0, 8'h0);
        check(holdWidth, 8);
        axi_rd(OFS_RDATA);
        check(rd, 32'hc3);
        $display("hold test done");
        set_bank(OFS_BANK0, 3'h2, 3'h1, 3'h1, 5'h01);
        set_bank(OFS_BANK1, 3'h7, 3'h1, 3'h1, 5'h01);
        foreach (gapCase[i]) begin
            axi_wr(OFS_CTRL, {30'h0, gapCase[i][7], 1'b1});
            mem_op(gapCase[i][6], 1'b0, 8'h0);
            mem_op(gapCase[i][5], gapCase[i][4], 8'h0);
            check(gapWidth >= 2 * (gapCase[i][3:0] + 1), 1'b1);
        end
        $display("turnaround test done");
        axi_wr(OFS_CTRL, 32'h1);
        set_bank(OFS_BANK0, 3'h0, 3'h0, 3'h0, 5'h05);
        stretchLen <= 8'h14;
        axi_wr(OFS_CMD, 32'h0);
        // mid-stretch: busy and stalled, last access a read
        repeat (16) @(posedge sys_clk);
        axi_rd(OFS_STATUS);
        check(rd, 32'h3);
        while (rd[STAT_BUSY_BIT] !== 1'b0) axi_rd(OFS_STATUS);
        check(lowWidth >= 8'h16, 1'b1);
        stretchLen <= 8'h0;
        $display("ack stretch test done");
        end_of_test();
    end
endmodule : test_async_memory_strobe_sequencer
bind async_memory_strobe_sequencer amem_monitor monitor (
    .sys_clk, .nrst, .bank_select_n, .read_strobe_n, .write_strobe_n, .memory_acknowledge,
    .memAddr, .memDataOut, .memDataOe
);
